// *** rtl/rsp_pkg.sv ***
// package: constants and carrier types for the radio host serial command port
package rsp_pkg;

    // ****************************************************************
    // serial framing
    // ****************************************************************
    localparam int          RSP_WORD_BITS  = 8;
    localparam logic [2:0]  RSP_LAST_BIT   = 3'h7;
    localparam logic [1:0]  RSP_IDX_CMD    = 2'h0;
    localparam logic [1:0]  RSP_IDX_ADDR   = 2'h1;
    localparam logic [1:0]  RSP_IDX_DATA   = 2'h2;
    localparam logic [1:0]  RSP_IDX_MAX    = 2'h3;

    // ****************************************************************
    // command codes
    // ****************************************************************
    localparam logic [7:0]  RSP_NO_OP_BYTE  = 8'hFF;
    localparam logic [4:0]  RSP_SEQ_WR_HEAD = 5'h03;   // 00011xxx
    localparam logic [4:0]  RSP_SEQ_RD_HEAD = 5'h07;   // 00111xxx
    localparam logic [1:0]  RSP_MEM_TOP     = 2'h0;    // memory class: 00xx1xxx
    localparam int          RSP_MEM_FLAG    = 3;
    localparam logic [2:0]  RSP_SPACE_PKT   = 3'h0;    // packet RAM
    localparam logic [2:0]  RSP_SPACE_BKP   = 3'h1;    // backup_config_ram
    localparam logic [2:0]  RSP_SPACE_MDM   = 3'h3;    // modem_config_ram
    localparam logic [2:0]  RSP_SPACE_PRG   = 3'h6;    // program RAM, write only

    // ****************************************************************
    // status word layout and register map
    // ****************************************************************
    localparam int          RSP_ST_PORT_RDY = 7;
    localparam int          RSP_ST_IRQ      = 6;
    localparam int          RSP_ST_CMD_RDY  = 5;
    localparam logic [10:0] RSP_IRQ_SRC2_ADDR  = 11'h337;  // irq_source_second
    localparam int          RSP_IS2_CMD_READY  = 6;
    localparam int          RSP_IS2_PORT_READY = 1;
    localparam int          RSP_IS2_CMD_DONE   = 0;
    localparam logic [7:0]  RSP_BYTE_RESET     = 8'h00;
    localparam logic [4:0]  RSP_STATE_INIT     = 5'h0F;

    // ****************************************************************
    // carriers
    // ****************************************************************
    typedef enum logic [1:0] {RSP_OP_NONE, RSP_OP_WRITE, RSP_OP_READ} rsp_op_t;

    typedef struct packed {
        logic        port_ready;   // memory side may be accessed
        logic        irq_level;    // level of irq_out_pin
        logic [4:0]  state;        // processor_state_field
    } rsp_radio_stat_t;

    typedef struct packed {
        logic        valid;        // queue holds a processor command
        logic [7:0]  code;
    } rsp_proc_cmd_t;

    typedef struct packed {
        logic        req;          // one-cycle strobe
        logic        we;
        logic [10:0] addr;
        logic [7:0]  wdata;
    } rsp_mem_req_t;

endpackage : rsp_pkg

// *** rtl/rsp_cmd_port.sv ***
// module: host serial command port with one-deep processor queue and memory controller
`timescale 1ns/1ps

module rsp_cmd_port
    import rsp_pkg::*;
(
    input  wire logic                     clk_i,
    input  wire logic                     nrst_i,
    input  wire logic                     sclk_i,
    input  wire logic                     cs_n_i,
    input  wire logic                     mosi_i,
    output logic                          miso_o,
    output logic                          miso_oe_o,
    input  wire rsp_pkg::rsp_radio_stat_t radio_stat_i,
    input  wire logic                     cmd_take_i,
    input  wire logic                     cmd_done_i,
    input  wire logic [7:0]               irq_src_other_i,
    output rsp_pkg::rsp_proc_cmd_t        proc_cmd_o,
    output rsp_pkg::rsp_mem_req_t         mem_req_o,
    input  wire logic [7:0]               mem_rdata_i
);
    import rsp_pkg::*;

    // ****************************************************************
    // link domain: frame-scoped state
    // ****************************************************************
    // select high clears the frame counters asynchronously, so a
    // partial byte never completes and leaves no trace
    logic       frame_rst_n;
    logic [2:0] bit_cnt_reg;
    logic [1:0] byte_idx_reg;
    logic [6:0] shift_reg;
    logic [2:0] out_pos_reg;
    logic       first_byte_reg;

    // held across the crossing until the next byte completes
    logic [7:0] rx_hold_reg;
    logic [1:0] idx_hold_reg;
    logic       rx_tgl_reg;
    logic [7:0] out_byte_reg;

    // ****************************************************************
    // system domain
    // ****************************************************************
    logic       cs_meta_reg;
    logic       cs_sync_reg;
    logic       tgl_meta_reg;
    logic       tgl_sync_reg;
    logic       tgl_seen_reg;
    logic       byte_evt;
    logic [7:0] tx_byte_reg;
    rsp_op_t    op_reg;
    logic [10:0] ptr_reg;
    logic       rd_pend_reg;
    logic       rd_src2_reg;
    logic       queue_full_reg;
    logic [7:0] queue_code_reg;
    logic       cmd_done_reg;
    logic [7:0] status_word;
    logic [7:0] irq_src2_word;
    logic       is_mem_cmd;

    assign frame_rst_n = nrst_i & ~cs_n_i;

    // bit and byte counting on the rising serial edge, msb first
    always_ff @(posedge sclk_i or negedge frame_rst_n) begin
        if (!frame_rst_n) begin
            bit_cnt_reg  <= 3'h0;
            byte_idx_reg <= RSP_IDX_CMD;
            shift_reg    <= 7'h00;
        end else begin
            shift_reg   <= {shift_reg[5:0], mosi_i};
            bit_cnt_reg <= bit_cnt_reg + 3'h1;
            if (bit_cnt_reg == RSP_LAST_BIT && byte_idx_reg != RSP_IDX_MAX) begin
                byte_idx_reg <= byte_idx_reg + 2'h1;
            end
        end
    end

    // completed byte handed over by toggle on its last rising edge
    always_ff @(posedge sclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rx_hold_reg  <= RSP_BYTE_RESET;
            idx_hold_reg <= RSP_IDX_CMD;
            rx_tgl_reg   <= 1'b0;
        end else if (!cs_n_i && bit_cnt_reg == RSP_LAST_BIT) begin
            rx_hold_reg  <= {shift_reg, mosi_i};
            idx_hold_reg <= byte_idx_reg;
            rx_tgl_reg   <= ~rx_tgl_reg;
        end
    end

    // next outgoing byte taken at the end of each byte; the system side
    // prepared it during the byte before, so it stands still when sampled
    always_ff @(posedge sclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            out_byte_reg <= RSP_BYTE_RESET;
        end else if (!cs_n_i && bit_cnt_reg == RSP_LAST_BIT) begin
            out_byte_reg <= tx_byte_reg;
        end
    end

    // output bit position advances on the falling edge
    always_ff @(negedge sclk_i or negedge frame_rst_n) begin
        if (!frame_rst_n) begin
            out_pos_reg    <= 3'h0;
            first_byte_reg <= 1'b1;
        end else begin
            out_pos_reg    <= bit_cnt_reg;
            first_byte_reg <= (byte_idx_reg == RSP_IDX_CMD);
        end
    end

    // output must show the status msb the moment select falls, before any
    // edge, so this path is a mux rather than a flop
    assign miso_o    = first_byte_reg ? tx_byte_reg[~out_pos_reg]
                                      : out_byte_reg[~out_pos_reg];
    assign miso_oe_o = ~cs_n_i;

    // ****************************************************************
    // crossing into the system clock
    // ****************************************************************
    // two-stage synchronisers for select and the byte toggle
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cs_meta_reg  <= 1'b1;
            cs_sync_reg  <= 1'b1;
            tgl_meta_reg <= 1'b0;
            tgl_sync_reg <= 1'b0;
            tgl_seen_reg <= 1'b0;
        end else begin
            cs_meta_reg  <= cs_n_i;
            cs_sync_reg  <= cs_meta_reg;
            tgl_meta_reg <= rx_tgl_reg;
            tgl_sync_reg <= tgl_meta_reg;
            tgl_seen_reg <= tgl_sync_reg;
        end
    end

    assign byte_evt = tgl_sync_reg ^ tgl_seen_reg;

    // ****************************************************************
    // status word and interrupt source view
    // ****************************************************************
    assign status_word = {radio_stat_i.port_ready,
                          radio_stat_i.irq_level,
                          ~queue_full_reg,
                          radio_stat_i.state};

    always_comb begin
        irq_src2_word                     = irq_src_other_i;
        irq_src2_word[RSP_IS2_CMD_READY]  = ~queue_full_reg;
        irq_src2_word[RSP_IS2_PORT_READY] = radio_stat_i.port_ready;
        irq_src2_word[RSP_IS2_CMD_DONE]   = cmd_done_reg;
    end

    // memory class is 00xx1xxx; everything else except no-op is a processor command
    assign is_mem_cmd = (rx_hold_reg[7:6] == RSP_MEM_TOP) && rx_hold_reg[RSP_MEM_FLAG];

    // finished flag: set by the processor, cleared when the processor takes the queued command;
    // a finish in the same cycle as the clear wins
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cmd_done_reg <= 1'b0;
        end else if (cmd_done_i) begin
            cmd_done_reg <= 1'b1;
        end else if (proc_cmd_o.valid && cmd_take_i) begin
            cmd_done_reg <= 1'b0;
        end
    end

    // ****************************************************************
    // processor command queue, one entry deep
    // ****************************************************************
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            queue_full_reg <= 1'b0;
            queue_code_reg <= RSP_BYTE_RESET;
        end else if (byte_evt && idx_hold_reg == RSP_IDX_CMD && !is_mem_cmd
                     && rx_hold_reg != RSP_NO_OP_BYTE && !queue_full_reg) begin
            queue_full_reg <= 1'b1;
            queue_code_reg <= rx_hold_reg;
        end else if (queue_full_reg && cmd_take_i) begin
            queue_full_reg <= 1'b0;
        end
        // a command landing on a full queue leaves it untouched
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            proc_cmd_o <= '0;
        end else begin
            proc_cmd_o.valid <= queue_full_reg & ~cmd_take_i;
            proc_cmd_o.code  <= queue_code_reg;
        end
    end

    // ****************************************************************
    // memory access controller
    // ****************************************************************
    // runs beside the queue and never looks at processor state, so memory
    // stays reachable while the radio is busy
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            op_reg  <= RSP_OP_NONE;
            ptr_reg <= 11'h000;
        end else if (cs_sync_reg) begin
            op_reg <= RSP_OP_NONE;
        end else if (byte_evt) begin
            unique case (idx_hold_reg)
                RSP_IDX_CMD: begin
                    op_reg  <= RSP_OP_NONE;
                    ptr_reg <= {rx_hold_reg[2:0], 8'h00};
                    if (rx_hold_reg[7:3] == RSP_SEQ_WR_HEAD
                        && (rx_hold_reg[2:0] == RSP_SPACE_PKT || rx_hold_reg[2:0] == RSP_SPACE_BKP
                            || rx_hold_reg[2:0] == RSP_SPACE_MDM
                            || rx_hold_reg[2:0] == RSP_SPACE_PRG)) begin
                        op_reg <= RSP_OP_WRITE;
                    end else if (rx_hold_reg[7:3] == RSP_SEQ_RD_HEAD
                                 && (rx_hold_reg[2:0] == RSP_SPACE_PKT
                                     || rx_hold_reg[2:0] == RSP_SPACE_BKP
                                     || rx_hold_reg[2:0] == RSP_SPACE_MDM)) begin
                        op_reg <= RSP_OP_READ;
                    end
                end
                RSP_IDX_ADDR: begin
                    ptr_reg[7:0] <= rx_hold_reg;
                    if (op_reg == RSP_OP_READ) begin
                        ptr_reg <= {ptr_reg[10:8], rx_hold_reg} + 11'h001;
                    end
                end
                default: begin
                    if (op_reg != RSP_OP_NONE) begin
                        ptr_reg <= ptr_reg + 11'h001;
                    end
                end
            endcase
        end
    end

    // memory strobe: writes carry the data byte, reads fetch a byte ahead
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            mem_req_o   <= '0;
            rd_pend_reg <= 1'b0;
            rd_src2_reg <= 1'b0;
        end else begin
            mem_req_o.req <= 1'b0;
            rd_pend_reg   <= 1'b0;
            if (byte_evt && !cs_sync_reg && op_reg == RSP_OP_READ && idx_hold_reg != RSP_IDX_CMD) begin
                mem_req_o.req   <= 1'b1;
                mem_req_o.we    <= 1'b0;
                mem_req_o.addr  <= (idx_hold_reg == RSP_IDX_ADDR) ? {ptr_reg[10:8], rx_hold_reg}
                                                                    : ptr_reg;
                rd_pend_reg     <= 1'b1;
                rd_src2_reg     <= ((idx_hold_reg == RSP_IDX_ADDR) ? {ptr_reg[10:8], rx_hold_reg}
                                                                     : ptr_reg) == RSP_IRQ_SRC2_ADDR;
            end else if (byte_evt && !cs_sync_reg && op_reg == RSP_OP_WRITE
                         && idx_hold_reg >= RSP_IDX_DATA) begin
                mem_req_o.req   <= 1'b1;
                mem_req_o.we    <= 1'b1;
                mem_req_o.addr  <= ptr_reg;
                mem_req_o.wdata <= rx_hold_reg;
            end
        end
    end

    // ****************************************************************
    // outgoing byte source
    // ****************************************************************
    // status between frames and for every byte not replaced by read data;
    // the interrupt source view is served here rather than from memory
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            tx_byte_reg <= RSP_BYTE_RESET;
        end else if (cs_sync_reg) begin
            tx_byte_reg <= status_word;
        end else if (rd_pend_reg) begin
            tx_byte_reg <= rd_src2_reg ? irq_src2_word : mem_rdata_i;
        end else if (byte_evt && op_reg != RSP_OP_READ) begin
            tx_byte_reg <= status_word;
        end
    end

endmodule : rsp_cmd_port

// *** bench/rsp_cmd_port_asserts.sv ***
// assertion checker for the host serial command port
`timescale 1ns/1ps
module rsp_cmd_port_chk
    import rsp_pkg::*;
(
    input  wire logic                     clk_i,
    input  wire logic                     nrst_i,
    input  wire logic                     sclk_i,
    input  wire logic                     cs_n_i,
    input  wire logic                     miso_o,
    input  wire logic                     miso_oe_o,
    input  wire rsp_pkg::rsp_radio_stat_t radio_stat_i,
    input  wire logic                     cmd_take_i,
    input  wire rsp_pkg::rsp_proc_cmd_t   proc_cmd_o,
    input  wire rsp_pkg::rsp_mem_req_t    mem_req_o
);
    // ****************************************************************
    // helper counters
    // ****************************************************************
    logic [3:0] idle_cnt_reg;   // clocks since select was last low
    logic [2:0] rdy_age_reg;    // clocks port_ready has kept its value
    logic       rdy_last_reg;

    // saturating, so a strobe long after a frame still shows up
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) idle_cnt_reg <= 4'hF;
        else if (!cs_n_i) idle_cnt_reg <= 4'h0;
        else if (idle_cnt_reg != 4'hF) idle_cnt_reg <= idle_cnt_reg + 4'h1;
    end

    // age of port_ready, the msb check only trusts a settled level
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rdy_age_reg  <= 3'h0;
            rdy_last_reg <= 1'b0;
        end else begin
            rdy_last_reg <= radio_stat_i.port_ready;
            rdy_age_reg  <= (radio_stat_i.port_ready != rdy_last_reg) ? 3'h0
                                                                       : rdy_age_reg + {2'h0, rdy_age_reg != 3'h7};
        end
    end

    // ****************************************************************
    // properties
    // ****************************************************************
    sequence s_queued;
        proc_cmd_o.valid && !cmd_take_i;
    endsequence
    sequence s_popped;
        proc_cmd_o.valid && cmd_take_i;
    endsequence

    chk_oe_tracks_cs: assert property (@(posedge clk_i) disable iff (!nrst_i)
        cs_n_i && idle_cnt_reg >= 4'h4 && rdy_age_reg >= 3'h2 && $stable(radio_stat_i.port_ready)
        |-> !miso_oe_o && miso_o == radio_stat_i.port_ready)
        else $error("idle output not showing port ready");
    chk_oe_on_sclk: assert property (@(posedge sclk_i) disable iff (!nrst_i)
        !cs_n_i |-> miso_oe_o) else $error("output not driven on a serial edge");
    chk_msb_at_select: assert property (@(posedge clk_i) disable iff (!nrst_i)
        $fell(cs_n_i) && rdy_age_reg == 3'h7 |-> miso_o == radio_stat_i.port_ready)
        else $error("status msb missing at select");
    chk_queue_holds: assert property (@(posedge clk_i) disable iff (!nrst_i)
        s_queued |=> proc_cmd_o.valid && $stable(proc_cmd_o.code)) else $error("queued command lost");
    chk_queue_pops: assert property (@(posedge clk_i) disable iff (!nrst_i)
        s_popped |=> !proc_cmd_o.valid) else $error("queue not emptied by take");
    chk_fill_in_frame: assert property (@(posedge clk_i) disable iff (!nrst_i)
        $rose(proc_cmd_o.valid) |-> idle_cnt_reg <= 4'h6) else $error("queue filled without a frame");
    chk_req_in_frame: assert property (@(posedge clk_i) disable iff (!nrst_i)
        mem_req_o.req |-> idle_cnt_reg <= 4'h6) else $error("memory access after frame end");
    chk_req_single: assert property (@(posedge clk_i) disable iff (!nrst_i)
        mem_req_o.req |=> !mem_req_o.req) else $error("memory strobe longer than a cycle");
    chk_fields_hold: assert property (@(posedge clk_i) disable iff (!nrst_i)
        !mem_req_o.req |-> $stable(mem_req_o[19:0])) else $error("memory fields moved without strobe");
endmodule : rsp_cmd_port_chk

bind rsp_cmd_port rsp_cmd_port_chk chk_u (.clk_i(clk_i), .nrst_i(nrst_i), .sclk_i(sclk_i), .cs_n_i(cs_n_i),
    .miso_o(miso_o), .miso_oe_o(miso_oe_o), .radio_stat_i(radio_stat_i), .cmd_take_i(cmd_take_i),
    .proc_cmd_o(proc_cmd_o), .mem_req_o(mem_req_o));

// *** bench/rsp_host_model.sv ***
// host serial master model that runs whole frames into the command port
`timescale 1ns/1ps
module rsp_host_model (
    output logic      sclk_o,
    output logic      cs_n_o,
    output logic      mosi_o,
    input  wire logic miso_i
);
    // ****************************************************************
    // frame engine
    // ****************************************************************
    logic [7:0] tx_a [16];
    logic [7:0] rx_a [16];
    int         gap_ns = 0;   // idle between bytes, models a slow host

    // serial clock stands still low outside frames
    initial begin
        sclk_o = 1'b0;
        cs_n_o = 1'b1;
        mosi_o = 1'b1;
    end

    // n bytes, the last cut after cut bits when cut is nonzero
    task automatic run_frame(input int n, input int cut);
        int nb;
        #37 cs_n_o = 1'b0;
        for (int b = 0; b < n; b++) begin
            nb = (b == n - 1 && cut > 0) ? cut : 8;
            for (int i = 7; i > 7 - nb; i--) begin
                mosi_o = tx_a[b][i];
                #62.5 sclk_o = 1'b1;
                rx_a[b][i] = miso_i;
                #62.5 sclk_o = 1'b0;
            end
            #(gap_ns);
        end
        #62.5 cs_n_o = 1'b1;
        mosi_o = ~mosi_o; // released line must not keep a stale level
        #500;
    endtask : run_frame
endmodule : rsp_host_model

// *** bench/tb_top.sv ***
// self-checking testbench for the host serial command port
`timescale 1ns/1ps
module tb_top;
    import rsp_pkg::*;
    // ****************************************************************
    // signals, models and design
    // ****************************************************************
    logic            clk_i      = 1'b0;
    logic            nrst_i     = 1'b0;
    wire logic       sclk_w, cs_n_w, mosi_w, miso_w, oe_w;
    rsp_radio_stat_t stat       = '0;
    logic            take       = 1'b0;
    logic            done       = 1'b0;
    logic [7:0]      other      = 8'h00;
    logic [7:0]      rdata      = 8'h00;
    rsp_proc_cmd_t   pcmd;
    rsp_mem_req_t    mreq;
    logic [7:0]      mem [2048];
    logic [18:0]     exp_wr [$];
    logic [31:0]     seed       = 32'hB1BD;
    logic [10:0]     a;
    int              n_mismatch = 0;
    int              checked    = 0;
    logic [4:0]      states [11] = '{5'h0F, 5'h00, 5'h11, 5'h12, 5'h13, 5'h14, 5'h06, 5'h05, 5'h08, 5'h09, 5'h0A};
    logic [7:0]      wcodes [4]  = '{8'h18, 8'h19, 8'h1B, 8'h1E};
    logic [7:0]      rcodes [3]  = '{8'h38, 8'h39, 8'h3B};

    always #50 clk_i = ~clk_i;

    rsp_host_model host_u (.sclk_o(sclk_w), .cs_n_o(cs_n_w), .mosi_o(mosi_w), .miso_i(miso_w));
    rsp_cmd_port dut_u (.clk_i(clk_i), .nrst_i(nrst_i), .sclk_i(sclk_w), .cs_n_i(cs_n_w), .mosi_i(mosi_w),
        .miso_o(miso_w), .miso_oe_o(oe_w), .radio_stat_i(stat), .cmd_take_i(take), .cmd_done_i(done),
        .irq_src_other_i(other), .proc_cmd_o(pcmd), .mem_req_o(mreq), .mem_rdata_i(rdata));

    // ****************************************************************
    // helpers
    // ****************************************************************
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr

    function automatic logic [7:0] status(input logic crdy);
        return {stat.port_ready, stat.irq_level, crdy, stat.state};
    endfunction : status

    task automatic chk(input logic [18:0] seen, input logic [18:0] exp, input string what);
        checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask : chk

    task automatic stop_test;
        $display("comparisons %0d, mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : stop_test

    // select stays high three clocks so the system side sees each frame end
    task automatic frame(input int n, input int cut);
        repeat (3) @(negedge clk_i);
        host_u.run_frame(n, cut);
    endtask : frame

    task automatic poll(input logic crdy);
        host_u.tx_a[0] = 8'hFF;
        host_u.tx_a[1] = 8'hFF;
        frame(2, 0);
        chk(host_u.rx_a[0], status(crdy), "status first byte");
        chk(host_u.rx_a[1], status(crdy), "status second byte");
    endtask : poll

    // memory side: writes compared with the model, reads answered half a cycle on
    always @(posedge clk_i) begin
        if (mreq.req === 1'b1 && mreq.we === 1'b1) begin
            chk({mreq.addr, mreq.wdata}, exp_wr.size() > 0 ? exp_wr.pop_front() : 19'h7FFFF, "write");
            mem[mreq.addr] = mreq.wdata;
        end
    end
    always @(negedge clk_i) begin
        if (mreq.req === 1'b1 && mreq.we === 1'b0) rdata <= mem[mreq.addr];
    end

    // a hang ends the run as a failure
    initial begin
        repeat (40000) @(posedge clk_i);
        n_mismatch++;
        stop_test();
    end

    // ****************************************************************
    // scenarios
    // ****************************************************************
    initial begin
        foreach (mem[i]) begin
            seed = lfsr(seed);
            mem[i] = seed[7:0];
        end
        repeat (6) @(negedge clk_i);
        nrst_i = 1'b1;
        foreach (states[k]) begin
            seed = lfsr(seed);
            @(negedge clk_i) stat = {seed[1:0], states[k]};
            poll(1'b1);
        end
        chk(oe_w, 1'b0, "output enable between frames");
        $display("test status done");
        // busy processor: cut byte dropped, one command queued, more ignored
        @(negedge clk_i) stat = {2'b10, 5'h00};
        poll(1'b1);
        host_u.tx_a[0] = 8'hB2;
        frame(1, 5);
        repeat (8) @(negedge clk_i);
        chk(pcmd.valid, 1'b0, "cut command byte");
        frame(1, 0);
        for (int i = 0; i < 30 && pcmd.valid !== 1'b1; i++) @(negedge clk_i);
        chk(pcmd, {1'b1, 8'hB2}, "queued command");
        if (pcmd.valid !== 1'b1) stop_test();
        poll(1'b0);
        host_u.tx_a[0] = 8'hC4;
        frame(1, 0);
        repeat (8) @(negedge clk_i);
        chk(pcmd, {1'b1, 8'hB2}, "command on full queue");
        $display("test queue done");
        // block writes to every space with the processor busy and queue full
        foreach (wcodes[k]) begin
            seed = lfsr(seed);
            a = {wcodes[k][2:0], seed[7:0]};
            host_u.tx_a[0] = wcodes[k];
            host_u.tx_a[1] = seed[7:0];
            host_u.gap_ns = (k % 2) * 700;
            for (int j = 0; j < 3; j++) begin
                seed = lfsr(seed);
                host_u.tx_a[2 + j] = seed[7:0];
                if (k < 3 || j < 2) exp_wr.push_back({a + 11'(j), seed[7:0]});
            end
            frame(5, k == 3 ? 4 : 0);
            repeat (8) @(negedge clk_i);
            chk(19'(exp_wr.size()), 19'h0, "writes outstanding");
        end
        host_u.gap_ns = 0;
        @(negedge clk_i) take = 1'b1;
        @(negedge clk_i) take = 1'b0;
        @(negedge clk_i);
        chk(pcmd.valid, 1'b0, "queue taken");
        poll(1'b1);
        $display("test write done");
        // block reads from each readable space, then the interrupt source view
        @(negedge clk_i) stat = {2'b11, 5'h12};
        foreach (rcodes[k]) begin
            seed = lfsr(seed);
            a = {rcodes[k][2:0], seed[7:0]};
            host_u.tx_a[0] = rcodes[k];
            host_u.tx_a[1] = seed[7:0];
            for (int j = 2; j < 5; j++) host_u.tx_a[j] = 8'hFF;
            frame(5, 0);
            chk(host_u.rx_a[0], status(1'b1), "read frame status");
            chk(host_u.rx_a[3], mem[a], "first read byte");
            chk(host_u.rx_a[4], mem[a + 11'h1], "next read byte");
        end
        seed = lfsr(seed);
        @(negedge clk_i) other = seed[7:0];
        done = 1'b1;
        @(negedge clk_i) done = 1'b0;
        host_u.tx_a[0] = 8'h3B;
        host_u.tx_a[1] = 8'h37;
        frame(4, 0);
        chk(host_u.rx_a[3], {other[7], 1'b1, other[5:2], stat.port_ready, 1'b1}, "interrupt source");
        $display("test read done");
        stop_test();
    end
endmodule : tb_top
